// ### scu_pkg.sv
package scu_pkg;

  // ----------------------------------------------------------------
  // I/O locations of the timer, one byte each
  // ----------------------------------------------------------------
  localparam logic [3:0] A_CTL_A  = 4'h0; // timer_control_a
  localparam logic [3:0] A_CTL_B  = 4'h1; // timer_control_b
  localparam logic [3:0] A_CNT_L  = 4'h2; // counter_low_byte
  localparam logic [3:0] A_CNT_H  = 4'h3; // counter_high_byte
  localparam logic [3:0] A_CMPA_L = 4'h4; // Compare value A low
  localparam logic [3:0] A_CMPA_H = 4'h5; // Compare value A high
  localparam logic [3:0] A_CMPB_L = 4'h6; // Compare value B low
  localparam logic [3:0] A_CMPB_H = 4'h7; // Compare value B high
  localparam logic [3:0] A_CAP_L  = 4'h8; // Capture value low
  localparam logic [3:0] A_CAP_H  = 4'h9; // Capture value high
  localparam logic [3:0] A_FLAG   = 4'hA; // Overflow flag register

  // ----------------------------------------------------------------
  // Field positions, values after reset, fixed counter values
  // ----------------------------------------------------------------
  localparam int         CTLA_WGM_LSB = 0;      // Mode bits 1:0 in A
  localparam int         CTLB_CS_LSB  = 0;      // Clock select in B
  localparam int         CTLB_WGM_LSB = 3;      // Mode bits 3:2 in B
  localparam int         FLAG_OVF_BIT = 0;      // Overflow flag bit
  localparam logic [7:0]  RST_BYTE    = 8'h00;  // Byte registers
  localparam logic [15:0] RST_WORD    = 16'h0000; // Word registers
  localparam logic [15:0] CNT_BOTTOM  = 16'h0000; // Bottom value
  localparam logic [15:0] CNT_MAX     = 16'hFFFF; // Maximum value
  localparam logic [15:0] TOP_8BIT    = 16'h00FF; // Fixed tops
  localparam logic [15:0] TOP_9BIT    = 16'h01FF;
  localparam logic [15:0] TOP_10BIT   = 16'h03FF;

  // ----------------------------------------------------------------
  // Clock select codes
  // ----------------------------------------------------------------
  localparam logic [2:0] CS_STOP  = 3'h0; // No clock, timer stopped
  localparam logic [2:0] CS_SYS   = 3'h1; // Every system clock
  localparam logic [2:0] CS_PRE_L = 3'h2; // First prescaled tick
  localparam logic [2:0] CS_PRE_H = 3'h5; // Last prescaled tick
  localparam logic [2:0] CS_EXT_F = 3'h6; // External, falling edge
  localparam logic [2:0] CS_EXT_R = 3'h7; // External, rising edge

  // Counting sequence class of a waveform mode
  typedef enum logic [1:0] {
    SEQ_NORMAL,  // Free running up to maximum
    SEQ_CTC,     // Clear at top, overflow at maximum
    SEQ_FAST,    // Clear at top, overflow at top
    SEQ_UPDOWN   // Up to top then down, overflow at bottom
  } scu_seq_e;

  // CPU byte access on the I/O bus
  typedef struct packed {
    logic       wr;    // Write strobe
    logic       rd;    // Read strobe
    logic [3:0] addr;  // I/O location
    logic [7:0] wdata; // Write data
  } scu_io_s;

endpackage

// ### scu_counter.sv
// How it works
// - Tick from internal or external source
// - Three-bit clock select in control B
// - Select zero stops counting and clearing
// - Each tick clears, increments or decrements
// - Count strobe moves by one, direction chosen
// - Clear forces all sixteen bits zero
// - Top and bottom indications are output
// - Counter seen as high and low bytes
// - High location reaches the holding register
// - Low read copies upper byte to holding
// - Low write loads holding plus data
// - Whole word moves in one cycle
// - CPU access works with no tick
// - CPU write beats count or clear
// - Four-bit mode split across controls
// - Overflow flag set per mode, interrupt
// - One holding register for all words
// - Compare reads bypass the holding register
// - Bottom is 0x0000, maximum is 0xFFFF
`timescale 1ns/1ps
`default_nettype none
module scu_counter
  import scu_pkg::*;
(
  // Clock and reset
  input  wire logic        REF_CLK,
  input  wire logic        RST,
  // CPU I/O bus
  input  wire scu_io_s     IO_REQ,
  output logic [7:0]       IO_RDATA,
  // Tick sources
  input  wire logic [3:0]  PRESC_TICK,
  input  wire logic        EXT_CLK,
  // Interrupt service
  input  wire logic        OVF_ACK,
  // Status towards the rest of the timer
  output logic             OVF_FLAG,
  output logic             CNT_TOP,
  output logic             CNT_BOTTOM_O,
  output logic [15:0]      COUNTER_VALUE,
  output logic [3:0]       WAVE_MODE
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [1:0]  wgm_lo;  // Mode bits 1:0
    logic [1:0]  wgm_hi;  // Mode bits 3:2
    logic [2:0]  cs;      // Clock source select
    logic [15:0] cnt;     // counter_value
    logic [7:0]  temp;    // Shared high-byte holding register
    logic [15:0] cmpa;    // Compare value A
    logic [15:0] cmpb;    // Compare value B
    logic [15:0] cap;     // Capture value
    logic        up;      // Direction, 1 counts up
    logic        ovf;     // overflow_flag
    logic        top;     // Counter at top
    logic        bot;     // Counter at bottom
    logic [7:0]  rdata;   // Read data
    logic [2:0]  sync;    // External clock synchroniser
    logic        lvl;     // Filtered external level
  } scu_state_s;

  scu_state_s q;          // Registered state
  scu_state_s d;          // Next state

  // ----------------------------------------------------------------
  // Decoding helpers
  // ----------------------------------------------------------------
  // Sequence class of a four-bit mode
  function automatic scu_seq_e seq_of(input logic [3:0] m);
    case (m)
      4'h1, 4'h2, 4'h3, 4'h8,
      4'h9, 4'hA, 4'hB:        seq_of = SEQ_UPDOWN;
      4'h4, 4'hC:              seq_of = SEQ_CTC;
      4'h5, 4'h6, 4'h7,
      4'hE, 4'hF:              seq_of = SEQ_FAST;
      default:                 seq_of = SEQ_NORMAL;
    endcase
  endfunction

  // Top value of a four-bit mode
  function automatic logic [15:0] top_of(input logic [3:0] m,
                                         input logic [15:0] ca,
                                         input logic [15:0] ic);
    case (m)
      4'h1, 4'h5:              top_of = TOP_8BIT;
      4'h2, 4'h6:              top_of = TOP_9BIT;
      4'h3, 4'h7:              top_of = TOP_10BIT;
      4'h4, 4'h9, 4'hB, 4'hF:  top_of = ca;
      4'h8, 4'hA, 4'hC, 4'hE:  top_of = ic;
      default:                 top_of = CNT_MAX;
    endcase
  endfunction

  // Capture value writable only where it defines top
  function automatic logic cap_is_top(input logic [3:0] m);
    cap_is_top = (m == 4'h8) || (m == 4'hA) ||
                 (m == 4'hC) || (m == 4'hE);
  endfunction

  // ----------------------------------------------------------------
  // Combinational helpers
  // ----------------------------------------------------------------
  logic [3:0]  mode;      // Joined waveform mode
  logic [15:0] top_val;   // Current top
  scu_seq_e    seq;       // Current sequence class
  logic        tick;      // timer_tick
  logic        ext_rise;  // Filtered external rising edge
  logic        ext_fall;  // Filtered external falling edge
  logic        cnt_wr;    // CPU writes the counter
  logic        do_count;  // Count strobe
  logic        do_up;     // Direction of the count
  logic        do_clear;  // Clear strobe
  logic        ovf_set;   // Overflow event
  logic        ovf_clr;   // Overflow clear request

  assign mode    = {q.wgm_hi, q.wgm_lo};
  assign top_val = top_of(mode, q.cmpa, q.cap);
  assign seq     = seq_of(mode);
  assign cnt_wr  = IO_REQ.wr && (IO_REQ.addr == A_CNT_L);

  // Filtered edges; only sync[2:1] and lvl are looked at
  assign ext_rise = (q.sync[1] == q.sync[2]) && q.sync[2] && !q.lvl;
  assign ext_fall = (q.sync[1] == q.sync[2]) && !q.sync[2] && q.lvl;

  // ----------------------------------------------------------------
  // Clock select: one tick enable from the chosen source
  // ----------------------------------------------------------------
  always_comb
  begin
    case (q.cs)
      CS_STOP:  tick = 1'b0;
      CS_SYS:   tick = 1'b1;
      CS_EXT_F: tick = ext_fall;
      CS_EXT_R: tick = ext_rise;
      default:  tick = PRESC_TICK[2'(q.cs - CS_PRE_L)];
    endcase
  end

  // ----------------------------------------------------------------
  // Sequence control: count, direction, clear and overflow
  // ----------------------------------------------------------------
  always_comb
  begin
    do_count = 1'b0;
    do_up    = 1'b1;
    do_clear = 1'b0;
    ovf_set  = 1'b0;
    if (tick && !cnt_wr)
    begin
      case (seq)
        SEQ_UPDOWN:
        begin
          do_count = 1'b1;
          if (q.up)
            do_up = (q.cnt != top_val);
          else
            do_up = (q.cnt == CNT_BOTTOM);
          ovf_set = !q.up && (q.cnt == CNT_BOTTOM);
        end
        SEQ_CTC:
        begin
          do_clear = (q.cnt == top_val);
          do_count = !do_clear;
          ovf_set  = (q.cnt == CNT_MAX);
        end
        SEQ_FAST:
        begin
          do_clear = (q.cnt == top_val);
          do_count = !do_clear;
          ovf_set  = do_clear;
        end
        default:
        begin
          do_count = 1'b1;
          ovf_set  = (q.cnt == CNT_MAX);
        end
      endcase
    end
  end

  assign ovf_clr = OVF_ACK || (IO_REQ.wr && (IO_REQ.addr == A_FLAG) &&
                   IO_REQ.wdata[FLAG_OVF_BIT]);

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb
  begin
    d = q;
    // External clock synchroniser and filter
    d.sync = {q.sync[1:0], EXT_CLK};
    if (q.sync[1] == q.sync[2])
      d.lvl = q.sync[2];
    // Counter operations; CPU write handled below wins
    if (do_clear)
      d.cnt = CNT_BOTTOM;
    else if (do_count)
      d.cnt = do_up ? q.cnt + 16'h0001 : q.cnt - 16'h0001;
    if (seq == SEQ_UPDOWN)
      d.up = do_count ? do_up : q.up;
    else
      d.up = 1'b1;
    // Overflow flag: set wins over clear
    if (ovf_set)
      d.ovf = 1'b1;
    else if (ovf_clr)
      d.ovf = 1'b0;
    // CPU writes, served with or without a tick
    if (IO_REQ.wr)
    begin
      case (IO_REQ.addr)
        A_CTL_A:  d.wgm_lo = IO_REQ.wdata[CTLA_WGM_LSB +: 2];
        A_CTL_B:
        begin
          d.cs     = IO_REQ.wdata[CTLB_CS_LSB +: 3];
          d.wgm_hi = IO_REQ.wdata[CTLB_WGM_LSB +: 2];
        end
        A_CNT_H, A_CMPA_H,
        A_CMPB_H, A_CAP_H: d.temp = IO_REQ.wdata;
        A_CNT_L:  d.cnt  = {q.temp, IO_REQ.wdata};
        A_CMPA_L: d.cmpa = {q.temp, IO_REQ.wdata};
        A_CMPB_L: d.cmpb = {q.temp, IO_REQ.wdata};
        A_CAP_L:
        begin
          if (cap_is_top(mode))
            d.cap = {q.temp, IO_REQ.wdata};
        end
        default:  d.cs = d.cs;
      endcase
    end
    // CPU reads, data registered for the next cycle
    if (IO_REQ.rd)
    begin
      case (IO_REQ.addr)
        A_CTL_A:  d.rdata = {6'h00, q.wgm_lo};
        A_CTL_B:  d.rdata = {3'h0, q.wgm_hi, q.cs};
        A_CNT_L:
        begin
          d.rdata = q.cnt[7:0];
          d.temp  = q.cnt[15:8];
        end
        A_CNT_H, A_CAP_H: d.rdata = q.temp;
        A_CMPA_L: d.rdata = q.cmpa[7:0];
        A_CMPA_H: d.rdata = q.cmpa[15:8];
        A_CMPB_L: d.rdata = q.cmpb[7:0];
        A_CMPB_H: d.rdata = q.cmpb[15:8];
        A_CAP_L:
        begin
          d.rdata = q.cap[7:0];
          d.temp  = q.cap[15:8];
        end
        A_FLAG:   d.rdata = {7'h00, q.ovf};
        default:  d.rdata = RST_BYTE;
      endcase
    end
    // Top and bottom indications of the new count
    d.top = (d.cnt == top_of({d.wgm_hi, d.wgm_lo}, d.cmpa, d.cap));
    d.bot = (d.cnt == CNT_BOTTOM);
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge REF_CLK or posedge RST)
  begin
    if (RST)
    begin
      q       <= '0;
      q.up    <= 1'b1;
      q.bot   <= 1'b1;
      q.cnt   <= RST_WORD;
      q.rdata <= RST_BYTE;
    end
    else
      q <= d;
  end

  // Outputs straight from the state register
  assign IO_RDATA      = q.rdata;
  assign OVF_FLAG      = q.ovf;
  assign CNT_TOP       = q.top;
  assign CNT_BOTTOM_O  = q.bot;
  assign COUNTER_VALUE = q.cnt;
  assign WAVE_MODE     = {q.wgm_hi, q.wgm_lo};

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (RST);

  a_stop_holds: assert property (q.cs == CS_STOP && !IO_REQ.wr
    |=> q.cnt == $past(q.cnt))
    else $error("counter moved while stopped");

  a_count_step: assert property (tick && seq == SEQ_NORMAL
    && !IO_REQ.wr |=> q.cnt == $past(q.cnt) + 16'h0001)
    else $error("normal count did not step by one");

  a_clear_zero: assert property (tick && seq == SEQ_FAST
    && q.cnt == top_val && !IO_REQ.wr |=> q.cnt == CNT_BOTTOM)
    else $error("clear at top did not zero counter");

  a_low_read_copy: assert property (IO_REQ.rd
    && IO_REQ.addr == A_CNT_L && !IO_REQ.wr
    |=> q.temp == $past(q.cnt[15:8]))
    else $error("low read did not copy upper byte");

  a_low_write_load: assert property (cnt_wr
    |=> q.cnt == {$past(q.temp), $past(IO_REQ.wdata)})
    else $error("low write did not load whole word");

  a_write_wins: assert property (cnt_wr && q.cs != CS_STOP
    |=> q.cnt[7:0] == $past(IO_REQ.wdata))
    else $error("count overrode cpu write");

  a_high_read_temp: assert property (IO_REQ.rd
    && IO_REQ.addr == A_CNT_H |=> IO_RDATA == $past(q.temp))
    else $error("high read bypassed holding register");

  a_cmp_direct: assert property (IO_REQ.rd && IO_REQ.addr == A_CMPA_H
    |=> IO_RDATA == $past(q.cmpa[15:8]))
    else $error("compare high read not direct");

  a_ovf_sticky: assert property (OVF_FLAG && !ovf_clr
    |=> OVF_FLAG)
    else $error("overflow flag dropped without clear");

  a_ovf_normal: assert property (tick && seq == SEQ_NORMAL
    && q.cnt == CNT_MAX && !IO_REQ.wr |=> OVF_FLAG && CNT_BOTTOM_O)
    else $error("no overflow at maximum wrap");

  // A tick that clears the count must show bottom right after
  a_bottom_flag: assert property (do_clear |=> CNT_BOTTOM_O)
    else $error("bottom indication missing after clear");

  c_wrap: cover property (ovf_set && seq == SEQ_NORMAL);
  c_turn: cover property (seq == SEQ_UPDOWN && q.up ##1 !q.up);
  c_write_tick: cover property (cnt_wr && tick);
  c_ext_tick: cover property (q.cs == CS_EXT_R && ext_rise);
  c_ctc_clear: cover property (do_clear && seq == SEQ_CTC);

endmodule
`default_nettype wire

// ### scu_dummy_guard.sv
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

// ### scu_cpu_model.sv
`timescale 1ns/1ps
`default_nettype none
module scu_cpu_model
  import scu_pkg::*;
(
  // Clock
  input  wire logic       REF_CLK,
  // I/O bus towards the timer
  output var  scu_io_s    IO_REQ,
  input  wire logic [7:0] IO_RDATA
);
  // --------------------------------------------------
  // Byte and word accesses of the CPU core
  // --------------------------------------------------
  // Bus idle from time zero
  initial IO_REQ = '0;

  // Write strobe stands one cycle, then released
  task automatic wr_byte(input logic [3:0] a, input logic [7:0] d);
    @(posedge REF_CLK);
    IO_REQ <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge REF_CLK);
    IO_REQ <= '0;
  endtask

  // Read data taken once the registered answer lands
  task automatic rd_byte(input logic [3:0] a, output logic [7:0] d);
    @(posedge REF_CLK);
    IO_REQ <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(posedge REF_CLK);
    IO_REQ <= '0;
    #1;
    d = IO_RDATA;
  endtask

  // High byte first, no other access in between
  task automatic wr_word(input logic [3:0] a, input logic [15:0] v);
    wr_byte(a + 4'h1, v[15:8]);
    wr_byte(a, v[7:0]);
  endtask

  // Low byte first so the holding register is fresh
  task automatic rd_word(input logic [3:0] a, output logic [15:0] v);
    rd_byte(a, v[7:0]);
    rd_byte(a + 4'h1, v[15:8]);
  endtask
endmodule
`default_nettype wire

// ### sixteen_bit_counter_unit_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module sixteen_bit_counter_unit_tb_top
  import scu_pkg::*;
;
  // Row: clock select, tick pattern, load, result
  typedef struct {
    logic [2:0]  cs;
    logic [3:0]  pat;
    logic [15:0] word;
    logic [15:0] exp;
  } scu_row_s;

  logic        clk;
  logic        rst;
  logic [3:0]  ptick;
  logic        ext;
  logic        ack;
  scu_io_s     req;
  logic [7:0]  rdata;
  logic        ovf;
  logic        top;
  logic        bot;
  logic [15:0] cnt;
  logic [3:0]  wmode;
  logic [15:0] rv;
  logic [7:0]  rb;
  int          n_fail;
  int          tests_run;
  int          cycles;
  int          i;
  scu_row_s    rows [8] = '{
    '{3'h2, 4'h1, 16'h01FF, 16'h0200}, '{3'h2, 4'h2, 16'hFFFF, 16'hFFFF},
    '{3'h3, 4'h2, 16'h0000, 16'h0001}, '{3'h3, 4'h1, 16'hA55A, 16'hA55A},
    '{3'h4, 4'h4, 16'h00FE, 16'h00FF}, '{3'h5, 4'h8, 16'h7FFF, 16'h8000},
    '{3'h5, 4'h7, 16'h1234, 16'h1234}, '{3'h0, 4'hF, 16'h0000, 16'h0000}};

  // Design and CPU model
  scu_counter i_scu_counter (.REF_CLK(clk), .RST(rst), .IO_REQ(req),
    .IO_RDATA(rdata), .PRESC_TICK(ptick), .EXT_CLK(ext), .OVF_ACK(ack),
    .OVF_FLAG(ovf), .CNT_TOP(top), .CNT_BOTTOM_O(bot),
    .COUNTER_VALUE(cnt), .WAVE_MODE(wmode));
  scu_cpu_model i_scu_cpu_model (.REF_CLK(clk), .IO_REQ(req),
    .IO_RDATA(rdata));

  // --------------------------------------------------
  // Helpers
  // --------------------------------------------------
  // Compare and count
  task automatic chk(input logic [15:0] got, input logic [15:0] exp,
                     input string what);
    tests_run++;
    if (got !== exp)
    begin
      n_fail++;
      $display("[FAIL] %0t %s: got %h want %h", $time, what, got, exp);
    end
  endtask

  // Let n edges pass, then settle
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  // Bounded wait for a counter value
  task automatic wait_cnt(input logic [15:0] v);
    for (int k = 0; k < 400 && cnt !== v; k++)
    begin
      @(posedge clk);
      #1;
    end
    chk(cnt, v, "counter reach");
  endtask

  // One line as each test ends
  task automatic end_test(input string s);
    $display("Test %s done", s);
  endtask

  // Summary and final verdict
  task automatic give_verdict();
    $display("Counts: %0d run, %0d failed", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // Clock and hang guard
  initial clk = 1'b0;
  always #5 clk = ~clk;
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 8000)
    begin
      n_fail++;
      $display("[FAIL] %0t run too long", $time);
      give_verdict();
    end
  end

  // --------------------------------------------------
  // Main sequence
  // --------------------------------------------------
  initial
  begin
    rst = 1'b1;
    ptick = 4'h0;
    ext = 1'b0;
    ack = 1'b0;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    #1;
    chk(cnt, 16'h0000, "reset count");
    chk({1'b0, ovf, top, bot, wmode, rdata}, 16'h1000, "reset flags");
    end_test("reset");
    // Table rows: load stopped, pulse tick pattern once, read back
    foreach (rows[k])
    begin
      i_scu_cpu_model.wr_byte(A_CTL_B, 8'h00);
      i_scu_cpu_model.wr_word(A_CNT_L, rows[k].word);
      i_scu_cpu_model.wr_byte(A_CTL_B, {5'h00, rows[k].cs});
      @(posedge clk);
      ptick <= rows[k].pat;
      @(posedge clk);
      ptick <= 4'h0;
      tick(3);
      i_scu_cpu_model.wr_byte(A_CTL_B, 8'h00);
      i_scu_cpu_model.rd_word(A_CNT_L, rv);
      chk(rv, rows[k].exp, "row value");
      chk({14'h0, bot, top}, {14'h0, rows[k].exp == 16'h0000,
          rows[k].exp == 16'hFFFF}, "row ends");
    end
    end_test("rows");
    // Free run wraps and sets a sticky flag
    i_scu_cpu_model.wr_word(A_CNT_L, 16'hFFFD);
    i_scu_cpu_model.wr_byte(A_CTL_B, 8'h01);
    wait_cnt(16'h0002);
    chk({15'h0, ovf}, 16'h0001, "wrap flag");
    i_scu_cpu_model.wr_byte(A_CTL_B, 8'h00);
    tick(4);
    chk({15'h0, ovf}, 16'h0001, "flag held");
    i_scu_cpu_model.wr_byte(A_FLAG, 8'h01);
    tick(1);
    chk({15'h0, ovf}, 16'h0000, "flag write clear");
    end_test("wrap");
    // Fixed top 0xFF: clear at top, flag, ack clears
    i_scu_cpu_model.wr_byte(A_CTL_A, 8'h01);
    i_scu_cpu_model.wr_word(A_CNT_L, 16'h00FD);
    i_scu_cpu_model.wr_byte(A_CTL_B, 8'h09);
    wait_cnt(16'h00FF);
    chk({11'h0, wmode, top}, 16'h000B, "mode and top");
    tick(1);
    chk(cnt, 16'h0000, "clear at top");
    tick(1);
    chk({15'h0, ovf}, 16'h0001, "top flag");
    i_scu_cpu_model.wr_byte(A_CTL_B, 8'h00);
    @(posedge clk);
    ack <= 1'b1;
    @(posedge clk);
    ack <= 1'b0;
    tick(1);
    chk({15'h0, ovf}, 16'h0000, "ack clear");
    end_test("fast");
    // Up/down: turn at top counts down
    i_scu_cpu_model.wr_word(A_CNT_L, 16'h00FD);
    i_scu_cpu_model.wr_byte(A_CTL_B, 8'h01);
    wait_cnt(16'h00FF);
    tick(1);
    chk(cnt, 16'h00FE, "down step");
    end_test("updown");
    // Write while counting wins over the tick
    i_scu_cpu_model.wr_byte(A_CTL_A, 8'h00);
    i_scu_cpu_model.wr_word(A_CNT_L, 16'h1234);
    #1;
    chk(cnt, 16'h1234, "write wins");
    tick(1);
    chk(cnt, 16'h1235, "count resumes");
    end_test("priority");
    // Holding register shared across word locations
    i_scu_cpu_model.wr_byte(A_CTL_B, 8'h00);
    i_scu_cpu_model.wr_byte(A_CMPA_H, 8'h5A);
    i_scu_cpu_model.wr_byte(A_CNT_L, 8'h3C);
    #1;
    chk(cnt, 16'h5A3C, "shared high");
    i_scu_cpu_model.rd_byte(A_CMPA_H, rb);
    chk({8'h00, rb}, 16'h0000, "compare direct");
    end_test("holding");
    // External pin: rising edges, then falling
    i_scu_cpu_model.wr_word(A_CNT_L, 16'h0000);
    i_scu_cpu_model.wr_byte(A_CTL_B, 8'h07);
    for (i = 0; i < 4; i++)
    begin
      if (i == 2)
        i_scu_cpu_model.wr_byte(A_CTL_B, 8'h06);
      @(posedge clk);
      ext <= ~ext;
      tick(8);
      chk(cnt, (i == 3) ? 16'h0002 : 16'h0001, "ext edge");
    end
    end_test("external");
    // Clear at top taken from compare A
    i_scu_cpu_model.wr_word(A_CMPA_L, 16'h0003);
    i_scu_cpu_model.wr_byte(A_CTL_B, 8'h08);
    i_scu_cpu_model.wr_word(A_CNT_L, 16'h0001);
    i_scu_cpu_model.wr_byte(A_CTL_B, 8'h09);
    wait_cnt(16'h0003);
    chk({15'h0, top}, 16'h0001, "ctc top");
    tick(1);
    chk(cnt, 16'h0000, "ctc clear");
    chk({15'h0, ovf}, 16'h0000, "ctc no flag");
    end_test("ctc");
    // Capture word: refused unless it sets top
    i_scu_cpu_model.wr_byte(A_CTL_B, 8'h08);
    i_scu_cpu_model.wr_word(A_CAP_L, 16'h4321);
    i_scu_cpu_model.rd_word(A_CAP_L, rv);
    chk(rv, 16'h0000, "capture refused");
    i_scu_cpu_model.wr_byte(A_CTL_B, 8'h18);
    i_scu_cpu_model.wr_word(A_CAP_L, 16'h4321);
    i_scu_cpu_model.rd_word(A_CAP_L, rv);
    chk(rv, 16'h4321, "capture as top");
    i_scu_cpu_model.rd_byte(4'hF, rb);
    chk({8'h00, rb}, 16'h0000, "unmapped read");
    end_test("capture");
    // Reset in mid-run returns all to idle
    i_scu_cpu_model.wr_byte(A_CTL_B, 8'h19);
    i_scu_cpu_model.rd_byte(A_CTL_B, rb);
    chk({8'h00, rb}, 16'h0019, "control b read");
    @(posedge clk);
    rst <= 1'b1;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    #1;
    chk({1'b0, ovf, top, bot, wmode, rdata}, 16'h1000, "mid reset flags");
    tick(2);
    chk(cnt, 16'h0000, "stopped after reset");
    end_test("mid reset");
    give_verdict();
  end
endmodule
`default_nettype wire
